// ---- sdcf_pkg.sv ----
// Purpose: constants and carriers for the sigma-delta filter and calibration control
// Assumes: one clock domain, plain register port
// Notes:   offsets are word indices on the register port
package sdcf_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] SDCF_OFS_MODE   = 4'h0;
  localparam logic [3:0] SDCF_OFS_STAT   = 4'h1;
  localparam logic [3:0] SDCF_OFS_DECIM  = 4'h2;
  localparam logic [3:0] SDCF_OFS_REFSEL = 4'h3;
  localparam logic [3:0] SDCF_OFS_DATA0  = 4'h4;
  localparam logic [3:0] SDCF_OFS_DATA1  = 4'h5;
  localparam logic [3:0] SDCF_OFS_OFF0   = 4'h6;
  localparam logic [3:0] SDCF_OFS_GAIN0  = 4'h7;
  localparam logic [3:0] SDCF_OFS_OFF1   = 4'h8;
  localparam logic [3:0] SDCF_OFS_GAIN1  = 4'h9;
  // mode register fields
  localparam int SDCF_MODE_MD_LSB   = 0;
  localparam int SDCF_MODE_CHOP_BIT = 3;
  localparam int SDCF_MODE_EN0_BIT  = 4;
  localparam int SDCF_MODE_EN1_BIT  = 5;
  localparam int SDCF_MODE_N60_BIT  = 6;
  // status register fields
  localparam int SDCF_ST_RDY0_BIT  = 0;
  localparam int SDCF_ST_RDY1_BIT  = 1;
  localparam int SDCF_ST_MISS_BIT  = 2;
  localparam int SDCF_ST_PRIMARY_CAL_ERROR_BIT  = 3;
  localparam int SDCF_ST_AUX_CAL_ERROR_BIT  = 4;
  localparam int SDCF_ST_MISS0_BIT = 5;
  localparam int SDCF_ST_MISS1_BIT = 6;
  // mode field codes
  localparam logic [2:0] SDCF_MD_IDLE   = 3'h0;
  localparam logic [2:0] SDCF_MD_INT_ZS = 3'h4;
  localparam logic [2:0] SDCF_MD_INT_FS = 3'h5;
  localparam logic [2:0] SDCF_MD_SYS_ZS = 3'h6;
  localparam logic [2:0] SDCF_MD_SYS_FS = 3'h7;
  // decimation limits, reset values, datapath codes and factory load length
  localparam logic [7:0]  SDCF_DECIM_MIN      = 8'h03;
  localparam logic [7:0]  SDCF_DECIM_CHOP_MIN = 8'h0d;
  localparam logic [7:0]  SDCF_DECIM_RST      = 8'h45;
  localparam logic [7:0]  SDCF_MODE_RST       = 8'h00;
  localparam logic [23:0] SDCF_MIDSCALE       = 24'h800000;
  localparam logic [23:0] SDCF_UNITY_GAIN     = 24'h400000;
  localparam logic [23:0] SDCF_CLAMP_CODE     = 24'hffffff;
  localparam int SDCF_FACT_TICKS = 2;

  typedef struct packed {
    logic [3:0]  addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } sdcf_bus_s;

  typedef struct packed {
    logic [23:0] off;
    logic [23:0] gain;
  } sdcf_coef_s;
endpackage : sdcf_pkg

// ---- sdcf_ctrl.sv ----
// Purpose: decimation, chop averaging, reference watch and calibration control
// Assumes: filter words arrive as one-cycle strobes per converter
// Notes:   analog modulator and sinc datapath sit outside this block
// Behaviour
// - missing main reference sets flag, clamps results, blocks calibration coefficient updates.
// - validity watch looks only at main reference pins, never the second.
// - reference lost during calibration suppresses coefficient write, sets converter error.
// - reference lost mid-calibration ends it at once with no write.
// - chop off: decimation word 3 to 255 used directly.
// - chop on: decimation words below 13 act as 13, top 255.
// - mode bit 6 enables the fixed 60 Hz notch.
// - calibration runs at the software decimation word, no special rate.
// - chop on: swap inputs, average each filter word with previous one.
// - mode bit 3 set disables chopping, clear keeps it active.
// - after reset factory coefficients load into each converter's calibration registers.
// - a software calibration overwrites the factory coefficients.
// - zero-scale result goes to offset, full-scale result to gain.
// - internal calibration connects inputs internally; system calibration uses applied voltage.
// - correction subtracts offset first, then multiplies by normalised gain.
// - calibration end shown by per-converter ready bit in status.
// - mode 100B starts internal zero-scale, 101B internal full-scale.
// - internal full-scale uses reference at gain 1; redo zero-scale afterwards.
// - mode 110B starts system zero-scale, 111B system full-scale.
// - bipolar zero-scale point maps to mid-scale code 800000H.
`timescale 1ns/1ps
`default_nettype none
module sdcf_ctrl #(
  parameter int NCONV = 2
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  // register port
  input  wire sdcf_pkg::sdcf_bus_s    bus,
  output logic [23:0]                 rdata,
  // factory coefficient store
  input  wire sdcf_pkg::sdcf_coef_s   fact_coef [NCONV],
  // reference detector
  input  wire logic                   main_ref_ok,
  input  wire logic                   second_ref_ok,
  // filter side
  input  wire logic [NCONV-1:0]       filt_valid,
  input  wire logic [23:0]            filt_word [NCONV],
  input  wire logic                   bipolar,
  // modulator control
  output logic [7:0]                  decim_factor,
  output logic                        notch60_enable,
  output logic                        chop_swap,
  output logic                        cal_int_input,
  output logic                        cal_fs_gain1,
  output logic [NCONV-1:0]            conv_enable
);
  import sdcf_pkg::*;

  // ****************************************************************
  // state and registers
  // ****************************************************************
  typedef enum logic [1:0] {SDCF_LOAD, SDCF_RUN, SDCF_CAL} sdcf_state_e;
  sdcf_state_e state_r, state_nxt;

  logic [7:0]        converter_mode_reg;
  logic [7:0]        decimation_word;
  logic [1:0]        ref_source_select;
  logic [NCONV-1:0]  conversion_ready_bits;
  logic [NCONV-1:0]  cal_err_r;
  logic [NCONV-1:0]  miss_conv_r;
  logic              ref_missing_flag;
  logic [23:0]       data_r [NCONV];
  logic [23:0]       prev_r [NCONV];
  logic [23:0]       off_r  [NCONV];
  logic [23:0]       gain_r [NCONV];
  logic [NCONV-1:0]  cal_tgt_r;
  logic [2:0]        cal_md_r;
  logic [1:0]        load_cnt_r;
  logic              swap_r;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire       wr_mode   = bus.wr && (bus.addr == SDCF_OFS_MODE);
  wire       wr_decim  = bus.wr && (bus.addr == SDCF_OFS_DECIM);
  wire       wr_refsel = bus.wr && (bus.addr == SDCF_OFS_REFSEL);
  wire [2:0] wr_md     = bus.wdata[SDCF_MODE_MD_LSB +: 3];
  wire       wr_is_cal = wr_mode && wr_md[2];
  wire [2:0] cur_md    = converter_mode_reg[SDCF_MODE_MD_LSB +: 3];
  wire       chop_on   = !converter_mode_reg[SDCF_MODE_CHOP_BIT];
  wire [NCONV-1:0] en_v = converter_mode_reg[SDCF_MODE_EN0_BIT +: NCONV];
  wire [NCONV-1:0] wr_en_v = bus.wdata[SDCF_MODE_EN0_BIT +: NCONV];
  wire       ref_bad   = !main_ref_ok;
  wire       unused_ok = second_ref_ok;

  // chop-off clamp to floor of 3
  wire [7:0] decim_lo  = (decimation_word < SDCF_DECIM_MIN) ? SDCF_DECIM_MIN : decimation_word;
  wire [7:0] decim_ch  = (decimation_word < SDCF_DECIM_CHOP_MIN) ? SDCF_DECIM_CHOP_MIN
                                                                : decimation_word;
  assign decim_factor   = chop_on ? decim_ch : decim_lo;
  assign notch60_enable = converter_mode_reg[SDCF_MODE_N60_BIT];
  assign chop_swap      = chop_on && swap_r;
  assign conv_enable    = en_v;
  assign cal_int_input  = (state_r == SDCF_CAL) && !cal_md_r[1];
  assign cal_fs_gain1   = (state_r == SDCF_CAL) && (cal_md_r == SDCF_MD_INT_FS);

  // ****************************************************************
  // per-converter datapath
  // ****************************************************************
  logic [23:0] avg_w  [NCONV];
  logic [23:0] corr_w [NCONV];
  logic [NCONV-1:0] cal_done_w;
  genvar g;
  generate
    for (g = 0; g < NCONV; g++) begin : g_conv
      wire [24:0] sum  = {1'b0, filt_word[g]} + {1'b0, prev_r[g]};
      wire [23:0] raw  = chop_on ? sum[24:1] : filt_word[g];
      wire [24:0] base = bipolar ? {1'b0, SDCF_MIDSCALE} : 25'h0000000;
      wire [24:0] dif  = {1'b0, raw} - {1'b0, off_r[g]};
      // full signed product, gain 1.0 sits at bit 22
      wire signed [49:0] dif_x  = 50'($signed(dif));
      wire signed [49:0] gain_x = 50'($signed({1'b0, gain_r[g]}));
      wire [49:0] prod = dif_x * gain_x;
      wire [24:0] scl  = prod[46:22] + base;
      assign avg_w[g]  = raw;
      // result below zero floors at code 0
      assign corr_w[g] = scl[24] ? 24'h000000 : scl[23:0];
      assign cal_done_w[g] = (state_r == SDCF_CAL) && cal_tgt_r[g] && filt_valid[g];

      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          prev_r[g] <= 24'h000000;
          data_r[g] <= 24'h000000;
        end else if (filt_valid[g]) begin
          prev_r[g] <= filt_word[g];
          data_r[g] <= ref_bad ? SDCF_CLAMP_CODE : corr_w[g];
        end
      end

      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          off_r[g]  <= 24'h000000;
          gain_r[g] <= SDCF_UNITY_GAIN;
        end else if (state_r == SDCF_LOAD) begin
          off_r[g]  <= fact_coef[g].off;
          gain_r[g] <= fact_coef[g].gain;
        end else if (cal_done_w[g] && !ref_bad) begin
          if (!cal_md_r[0]) begin
            off_r[g] <= avg_w[g];
          end else begin
            gain_r[g] <= avg_w[g];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // sequencing
  // ****************************************************************
  wire cal_any_done = |cal_done_w;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SDCF_LOAD: begin
        if (load_cnt_r == 2'(SDCF_FACT_TICKS - 1)) state_nxt = SDCF_RUN;
      end
      SDCF_RUN: begin
        if (wr_is_cal && (|(wr_en_v & {NCONV{1'b1}}))) state_nxt = SDCF_CAL;
      end
      SDCF_CAL: begin
        if (ref_bad || cal_any_done) state_nxt = SDCF_RUN;
      end
      default: state_nxt = SDCF_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= SDCF_LOAD;
      load_cnt_r <= 2'h0;
      cal_md_r   <= SDCF_MD_IDLE;
      cal_tgt_r  <= '0;
      swap_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      load_cnt_r <= (state_r == SDCF_LOAD) ? load_cnt_r + 2'h1 : 2'h0;
      if (state_r == SDCF_RUN && state_nxt == SDCF_CAL) begin
        cal_md_r  <= wr_md;
        cal_tgt_r <= wr_en_v;
      end
      if (|filt_valid) swap_r <= !swap_r;
    end
  end

  // ****************************************************************
  // registers and status
  // ****************************************************************
  wire cal_leave = (state_r == SDCF_CAL) && (state_nxt == SDCF_RUN);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      converter_mode_reg <= SDCF_MODE_RST;
      decimation_word    <= SDCF_DECIM_RST;
      ref_source_select  <= 2'h0;
    end else begin
      if (wr_mode) converter_mode_reg <= bus.wdata[7:0];
      else if (cal_leave) converter_mode_reg[SDCF_MODE_MD_LSB +: 3] <= SDCF_MD_IDLE;
      if (wr_decim) decimation_word <= bus.wdata[7:0];
      if (wr_refsel) ref_source_select <= bus.wdata[1:0];
    end
  end

  wire rd_stat = bus.rd && (bus.addr == SDCF_OFS_STAT);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conversion_ready_bits <= '0;
      cal_err_r             <= '0;
      miss_conv_r           <= '0;
      ref_missing_flag      <= 1'b0;
    end else begin
      ref_missing_flag <= ref_bad;
      // ready set wins over read clear
      conversion_ready_bits <= (rd_stat ? '0 : conversion_ready_bits)
                             | ((state_r == SDCF_CAL) ? cal_done_w : filt_valid);
      // error on reference loss in calibration
      cal_err_r <= (wr_is_cal ? '0 : cal_err_r)
                 | (((state_r == SDCF_CAL) && ref_bad) ? cal_tgt_r : '0);
      miss_conv_r <= (rd_stat ? '0 : miss_conv_r) | (ref_bad ? filt_valid : '0);
    end
  end

  wire [23:0] stat_w = {17'h00000, miss_conv_r, cal_err_r, ref_missing_flag,
                        conversion_ready_bits};
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 24'h000000;
    end else if (!bus.rd) begin
      rdata <= 24'h000000;
    end else if (bus.addr == SDCF_OFS_MODE) begin
      rdata <= {16'h0000, converter_mode_reg};
    end else if (bus.addr == SDCF_OFS_STAT) begin
      rdata <= stat_w;
    end else if (bus.addr == SDCF_OFS_DECIM) begin
      rdata <= {16'h0000, decimation_word};
    end else if (bus.addr == SDCF_OFS_REFSEL) begin
      rdata <= {22'h000000, ref_source_select};
    end else if (bus.addr == SDCF_OFS_DATA0) begin
      rdata <= data_r[0];
    end else if (bus.addr == SDCF_OFS_DATA1) begin
      rdata <= data_r[NCONV-1];
    end else if (bus.addr == SDCF_OFS_OFF0) begin
      rdata <= off_r[0];
    end else if (bus.addr == SDCF_OFS_GAIN0) begin
      rdata <= gain_r[0];
    end else if (bus.addr == SDCF_OFS_OFF1) begin
      rdata <= off_r[NCONV-1];
    end else if (bus.addr == SDCF_OFS_GAIN1) begin
      rdata <= gain_r[NCONV-1];
    end else begin
      rdata <= 24'h000000;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  cal_abort_a: assert property (
    (state_r == SDCF_CAL) && ref_bad |=> state_r == SDCF_RUN)
    else $error("calibration not ended on missing reference");
  coef_hold_a: assert property (
    ref_bad && state_r != SDCF_LOAD |=> $stable(off_r[0]) && $stable(gain_r[0]))
    else $error("coefficient changed without reference");
  cal_error_a: assert property (
    (state_r == SDCF_CAL) && ref_bad && cal_tgt_r[0] |=> cal_err_r[0])
    else $error("calibration error bit not set");
  chop_floor_a: assert property (
    chop_on |-> decim_factor >= SDCF_DECIM_CHOP_MIN)
    else $error("chop decimation below floor");
  nochop_pass_a: assert property (
    !chop_on && decimation_word >= SDCF_DECIM_MIN |-> decim_factor == decimation_word)
    else $error("decimation word not used directly");
  notch_bit_a: assert property (
    notch60_enable == converter_mode_reg[SDCF_MODE_N60_BIT])
    else $error("notch enable mismatch");
  clamp_out_a: assert property (
    ref_bad && filt_valid[0] |=> data_r[0] == SDCF_CLAMP_CODE)
    else $error("result not clamped");
  ready_set_a: assert property (
    cal_done_w[0] |=> conversion_ready_bits[0])
    else $error("ready bit not set at calibration end");
  flag_clear_a: assert property (
    !ref_bad |=> !ref_missing_flag)
    else $error("missing flag stuck");
  factory_ld_a: assert property (
    $rose(resetn) |-> ##1 off_r[0] == $past(fact_coef[0].off))
    else $error("factory offset not loaded");

  // ****************************************************************
  // calibration checks
  // ****************************************************************
  factory_gn_a: assert property (
    $rose(resetn) |-> ##1 gain_r[NCONV-1] == $past(fact_coef[NCONV-1].gain))
    else $error("factory gain not loaded");
  cal_error1_a: assert property (
    (state_r == SDCF_CAL) && ref_bad && cal_tgt_r[NCONV-1] |=> cal_err_r[NCONV-1])
    else $error("second calibration error bit not set");
  cal_start_a: assert property (
    (state_r == SDCF_RUN) && wr_is_cal && (|wr_en_v) |=> (state_r == SDCF_CAL)
      && (cal_md_r == $past(wr_md)))
    else $error("calibration not started by mode code");
  cal_refuse_a: assert property (
    (state_r == SDCF_RUN) && wr_is_cal && !(|wr_en_v) |=> state_r == SDCF_RUN)
    else $error("calibration started with no converter enabled");
  off_store_a: assert property (
    cal_done_w[0] && !ref_bad && !cal_md_r[0] |=> off_r[0] == $past(avg_w[0]))
    else $error("zero-scale result not stored in offset");
  gain_store_a: assert property (
    cal_done_w[0] && !ref_bad && cal_md_r[0] |=> gain_r[0] == $past(avg_w[0]))
    else $error("full-scale result not stored in gain");
  mode_idle_a: assert property (
    cal_leave && !wr_mode |=> cur_md == SDCF_MD_IDLE)
    else $error("mode field not idle after calibration");
  int_input_a: assert property (
    (state_r == SDCF_CAL) |-> cal_int_input
      == ((cal_md_r == SDCF_MD_INT_ZS) || (cal_md_r == SDCF_MD_INT_FS)))
    else $error("internal input select wrong for mode");
  gain1_a: assert property (
    cal_fs_gain1 |-> cal_int_input && (cal_md_r == SDCF_MD_INT_FS))
    else $error("gain one outside internal full-scale");
  cal_rate_a: assert property (
    (state_r == SDCF_CAL) && !chop_on && decimation_word >= SDCF_DECIM_MIN
      |-> decim_factor == decimation_word)
    else $error("calibration rate differs from software word");

  // ****************************************************************
  // filter and reference checks
  // ****************************************************************
  chop_off_a: assert property (
    !chop_on |-> !chop_swap)
    else $error("inputs reversed with chop disabled");
  swap_toggle_a: assert property (
    chop_on && (|filt_valid) && !wr_mode |=> chop_swap != $past(chop_swap))
    else $error("input reversal did not toggle");
  chop_mean_a: assert property (
    chop_on && filt_valid[0] && !ref_bad && !bipolar && (off_r[0] == 24'h000000)
      && (gain_r[0] == SDCF_UNITY_GAIN)
      |=> {1'b0, data_r[0]}
          == (({1'b0, $past(filt_word[0])} + {1'b0, $past(prev_r[0])}) >> 1))
    else $error("chop result not mean of last two words");
  clamp1_a: assert property (
    ref_bad && filt_valid[NCONV-1] |=> data_r[NCONV-1] == SDCF_CLAMP_CODE)
    else $error("second result not clamped");
  miss_set_a: assert property (
    ref_bad |=> ref_missing_flag)
    else $error("missing flag not set");
  second_ign_a: assert property (
    (state_r != SDCF_LOAD) && $stable(main_ref_ok) |=> $stable(ref_missing_flag))
    else $error("missing flag moved without main reference change");

  cal_ok_c:    cover property ((state_r == SDCF_CAL) ##[1:300] cal_done_w[0] && !ref_bad);
  cal_abort_c: cover property ((state_r == SDCF_CAL) && ref_bad);
  chop_avg_c:  cover property (chop_on && filt_valid[0] ##[1:300] filt_valid[0]);
  sys_fs_c:    cover property (wr_is_cal && wr_md == SDCF_MD_SYS_FS);
  chop_off_c:  cover property (!chop_on && filt_valid[0]);
endmodule : sdcf_ctrl
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for the filter and calibration control block
// Assumes: plain register port, read data valid only in the cycle after the strobe
// Notes:   the bench drives filter words, factory store and reference state directly
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sdcf_pkg::*;
  localparam int NCONV = 2;
  localparam int TMO   = 5000;

  logic                 ref_clk;
  logic                 resetn;
  sdcf_bus_s            bus;
  logic [23:0]          rdata;
  sdcf_coef_s           fact_coef [NCONV];
  logic                 main_ref_ok;
  logic                 second_ref_ok;
  logic [NCONV-1:0]     filt_valid;
  logic [23:0]          filt_word [NCONV];
  logic                 bipolar;
  logic [7:0]           decim_factor;
  logic                 notch60_enable;
  logic                 chop_swap;
  logic                 cal_int_input;
  logic                 cal_fs_gain1;
  logic [NCONV-1:0]     conv_enable;
  int                   errors;
  int                   num_checks;
  int                   cyc;
  logic [23:0]          v;
  logic                 prev;
  logic [7:0]           dw [6];
  logic [7:0]           de [6];

  sdcf_ctrl #(.NCONV(NCONV)) u_dut (
    .ref_clk        (ref_clk),
    .resetn         (resetn),
    .bus            (bus),
    .rdata          (rdata),
    .fact_coef      (fact_coef),
    .main_ref_ok    (main_ref_ok),
    .second_ref_ok  (second_ref_ok),
    .filt_valid     (filt_valid),
    .filt_word      (filt_word),
    .bipolar        (bipolar),
    .decim_factor   (decim_factor),
    .notch60_enable (notch60_enable),
    .chop_swap      (chop_swap),
    .cal_int_input  (cal_int_input),
    .cal_fs_gain1   (cal_fs_gain1),
    .conv_enable    (conv_enable)
  );

  // ****************************************************************
  // clock, timeout and helpers
  // ****************************************************************
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      errors = errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge ref_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge ref_clk);
    bus.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge ref_clk);
    bus.rd   <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [23:0] exp);
    logic [23:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rchk

  // one filter word, then time for the result to land
  task automatic pulse(input int n, input logic [23:0] w);
    @(posedge ref_clk);
    filt_word[n]  <= w;
    filt_valid[n] <= 1'b1;
    @(posedge ref_clk);
    filt_valid    <= '0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    bus = '0;
    resetn = 1'b0;
    main_ref_ok = 1'b1;
    second_ref_ok = 1'b0;
    filt_valid = '0;
    filt_word[0] = 24'h000000;
    filt_word[1] = 24'h000000;
    bipolar = 1'b0;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    fact_coef[0] = '{off: 24'h000000, gain: SDCF_UNITY_GAIN};
    fact_coef[1] = '{off: 24'h000100, gain: 24'h800000};
    dw = '{8'h05, 8'h0d, 8'hff, 8'h03, 8'hff, 8'h0c};
    de = '{8'h0d, 8'h0d, 8'hff, 8'h03, 8'hff, 8'h0c};
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rchk(SDCF_OFS_OFF0, 24'h000000);
    rchk(SDCF_OFS_GAIN0, SDCF_UNITY_GAIN);
    rchk(SDCF_OFS_OFF1, 24'h000100);
    rchk(SDCF_OFS_GAIN1, 24'h800000);
    rchk(SDCF_OFS_DECIM, {16'h0000, SDCF_DECIM_RST});
    wr(4'hf, 24'h00005a);
    rchk(4'hf, 24'h000000);
    // start code with no converter enabled is held, not run
    wr(SDCF_OFS_MODE, 24'h00000c);
    @(negedge ref_clk);
    chk(cal_int_input, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(SDCF_OFS_MODE, (i < 3) ? 24'h000000 : 24'h000008);
      wr(SDCF_OFS_DECIM, {16'h0000, dw[i]});
      @(negedge ref_clk);
      chk(decim_factor, de[i]);
    end
    wr(SDCF_OFS_DECIM, 24'h000052);
    wr(SDCF_OFS_MODE, 24'h000048);
    @(negedge ref_clk);
    chk(notch60_enable, 1'b1);
    // chop off: word passes straight, no input reversal
    wr(SDCF_OFS_MODE, 24'h000018);
    @(negedge ref_clk);
    chk(notch60_enable, 1'b0);
    prev = chop_swap;
    pulse(0, 24'h001000);
    chk(chop_swap, prev);
    rchk(SDCF_OFS_DATA0, 24'h001000);
    // chop on: reversal toggles, result is mean of last two words
    wr(SDCF_OFS_MODE, 24'h000010);
    @(negedge ref_clk);
    chk(conv_enable, 2'h1);
    prev = chop_swap;
    pulse(0, 24'h002000);
    chk(chop_swap, !prev);
    pulse(0, 24'h004000);
    rchk(SDCF_OFS_DATA0, 24'h003000);
    // offset first, then gain of 2.0
    wr(SDCF_OFS_MODE, 24'h000028);
    pulse(1, 24'h001100);
    rchk(SDCF_OFS_DATA1, 24'h002000);
    bipolar <= 1'b1;
    pulse(1, 24'h001100);
    rchk(SDCF_OFS_DATA1, 24'h802000);
    bipolar <= 1'b0;
    // every calibration code on converter 0, second reference held bad
    wr(SDCF_OFS_DECIM, 24'h000052);
    rd(SDCF_OFS_STAT, v);
    for (int k = 4; k < 8; k++) begin
      wr(SDCF_OFS_MODE, 24'h000018 | 24'(k));
      @(negedge ref_clk);
      chk(cal_int_input, (k < 6));
      chk(cal_fs_gain1, (k == 5));
      chk(decim_factor, 8'h52);
      pulse(0, 24'h100000 + 24'(k));
      rchk((k % 2 == 1) ? SDCF_OFS_GAIN0 : SDCF_OFS_OFF0, 24'h100000 + 24'(k));
      rchk(SDCF_OFS_STAT, 24'h000001);
      rchk(SDCF_OFS_MODE, 24'h000018);
    end
    // reference lost in mid-calibration on converter 1
    wr(SDCF_OFS_MODE, 24'h00002c);
    @(negedge ref_clk);
    chk(cal_int_input, 1'b1);
    @(posedge ref_clk);
    main_ref_ok <= 1'b0;
    second_ref_ok <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(cal_int_input, 1'b0);
    pulse(1, 24'h005555);
    rchk(SDCF_OFS_OFF1, 24'h000100);
    rchk(SDCF_OFS_DATA1, SDCF_CLAMP_CODE);
    rd(SDCF_OFS_STAT, v);
    chk(v[SDCF_ST_MISS_BIT], 1'b1);
    chk(v[SDCF_ST_MISS1_BIT], 1'b1);
    chk(v[SDCF_ST_AUX_CAL_ERROR_BIT], 1'b1);
    @(posedge ref_clk);
    main_ref_ok <= 1'b1;
    second_ref_ok <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(SDCF_OFS_STAT, v);
    chk(v[SDCF_ST_MISS_BIT], 1'b0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
